//--- core/shr_hang_timer.sv
`timescale 1ns/10ps
`default_nettype none
module shr_hang_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic state_i,
  input wire logic clear_i,
  input wire logic [31:0] period_i,
  output logic out_o
);
  logic [31:0] remain;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_o <= 1'b0;
      remain <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      if (clear_i)
      begin
        out_o <= 1'b0;
        remain <= 32'h0000_0000;
      end
      else if (load_i)
      begin
        out_o <= state_i; // [RULE8]
        remain <= state_i ? period_i - 32'h0000_0001 : 32'h0000_0000; // [RULE10] [RULE20]
      end
      else if (out_o)
      begin
        if (remain == 32'h0000_0000)
        begin
          out_o <= 1'b0; // [RULE9] [RULE3] [RULE13]
        end
        else
        begin
          remain <= remain - 32'h0000_0001;
        end
      end
    end
  end
endmodule : shr_hang_timer
`default_nettype wire

//--- core/shr_pkg.sv
// Notes on behaviour
// RULE1: straps 0 low, 1 and 2 high select 20 ms hang-time without serial filtering.
// RULE2: all three straps high select 20 ms hang-time with serial filtering.
// RULE3: in 20 ms modes outputs are active high and hold 20 ms unless refreshed.
// RULE4: in the non-network 20 ms mode the learn pin is never driven.
// RULE5: in network modes a high pulse on the learn pin starts learning; pin shows status.
// RULE6: output follows a transmitter input within 12 ms, typically about 5 ms.
// RULE7: in the four switch modes the block only receives, never transmits switch data.
// RULE8: each accepted packet sets the three outputs to its three states, all 8 combinations.
// RULE9: a high output drops once the hang-time passes with no further packet.
// RULE10: a packet keeping an output high restarts its full 20 ms or 500 ms period.
// RULE11: the remote transmitter repeats its state packet every 15 ms while inputs are high.
// RULE12: in 20 ms modes turning all outputs off costs only about 5 ms extra.
// RULE13: in 500 ms modes the last output holds 500 ms after the final release.
// RULE14: 500 ms hang-time suits relay loads since it rides over lost packets.
// RULE15: state packets from a serial-mode sender are handled like transmitter packets.
// RULE16: straps 0,1 low, 2 high or 0,2 high, 1 low select 500 ms modes.
// RULE17: first data byte bits 6, 5, 4 give outputs 3, 2, 1; one means high.
// RULE18: network modes accept a packet only if its header serial was learned; the code also accepts one whose data-field serial matches the unit's own.
// RULE19: straps are read again on every release of reset.
// RULE20: each output has its own hang timer, reloaded by a packet reporting it high.
package shr_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned HANG_SHORT_MS = 20;
  localparam int unsigned HANG_LONG_MS = 500;
  localparam int unsigned LEARN_WINDOW_MS = 10000;
  localparam logic [31:0] HANG_SHORT_CYC = 32'(CYC_PER_MS * HANG_SHORT_MS);
  localparam logic [31:0] HANG_LONG_CYC = 32'(CYC_PER_MS * HANG_LONG_MS);
  localparam logic [31:0] LEARN_CYC = 32'(CYC_PER_MS * LEARN_WINDOW_MS);
  localparam int unsigned SN_W = 32;
  localparam int unsigned TBL_AW = 3;
  localparam int unsigned TBL_DEPTH = 8;
  localparam int unsigned NUM_OUT = 3;
  localparam int unsigned STATE_LSB = 4;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  localparam logic [2:0] STRAP_SHORT = 3'h6;
  localparam logic [2:0] STRAP_SHORT_NET = 3'h7;
  localparam logic [2:0] STRAP_LONG = 3'h4;
  localparam logic [2:0] STRAP_LONG_NET = 3'h5;
  // own serial number: value is arbitrary
  localparam logic [SN_W-1:0] UNIT_SN_DEFAULT = 32'h0000_0001;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_ACCEPT_CNT = 8'h08;
  localparam logic [7:0] REG_REJECT_CNT = 8'h0C;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam int unsigned CTRL_OUT_OFF = 0;
  localparam int unsigned CTRL_LEARN = 1;
  localparam int unsigned CTRL_CLEAR = 2;
  localparam int unsigned ST_OUT_LSB = 0;
  localparam int unsigned ST_LEARNING = 3;
  localparam int unsigned ST_NET = 4;
  localparam int unsigned ST_LONG = 5;
  localparam int unsigned ST_ACTIVE = 6;
  localparam int unsigned ST_STRAP_LSB = 8;
  localparam int unsigned ST_COUNT_LSB = 12;
  typedef enum {ST_IDLE, ST_CHECK, ST_SCAN, ST_CMP, ST_APPLY} shr_state_t;
endpackage : shr_pkg

//--- core/shr_sn_table.sv
`timescale 1ns/10ps
`default_nettype none
module shr_sn_table
  import shr_pkg::*;
(
  input wire logic clk_i,
  input wire logic ce_i,
  shr_tbl_if.mem tbl
);
  logic [SN_W-1:0] mem [TBL_DEPTH];

  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      if (tbl.we)
      begin
        mem[tbl.waddr] <= tbl.wdata;
      end
      tbl.rdata <= mem[tbl.raddr];
    end
  end
endmodule : shr_sn_table
`default_nettype wire

//--- core/shr_switch_receiver.sv
`timescale 1ns/10ps
`default_nettype none
module shr_switch_receiver #(
  parameter logic [31:0] HANG_SHORT_CYC = shr_pkg::HANG_SHORT_CYC,
  parameter logic [31:0] HANG_LONG_CYC = shr_pkg::HANG_LONG_CYC,
  parameter logic [31:0] LEARN_CYC = shr_pkg::LEARN_CYC,
  parameter logic [shr_pkg::SN_W-1:0] UNIT_SN = shr_pkg::UNIT_SN_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [2:0] mode_sel_i,
  input wire logic learn_pin_i,
  output logic learn_pin_o,
  output logic learn_pin_oe_o,
  input wire logic pkt_valid_i,
  input wire logic [7:0] pkt_state_i,
  input wire logic [shr_pkg::SN_W-1:0] pkt_hdr_sn_i,
  input wire logic pkt_has_data_sn_i,
  input wire logic [shr_pkg::SN_W-1:0] pkt_data_sn_i,
  output logic switch_out_1_o,
  output logic switch_out_2_o,
  output logic switch_out_3_o,
  output logic pkt_busy_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import shr_pkg::*;

  logic [2:0] strap_meta;
  logic [2:0] strap_sync;
  logic [2:0] strap_mode;
  logic [1:0] strap_wait;
  logic strap_taken;
  logic learn_meta;
  logic learn_sync;
  logic learn_prev;
  logic learning;
  logic [31:0] learn_cnt;
  logic [CTRL_OUT_OFF:CTRL_OUT_OFF] ctrl_out_off;
  logic [TBL_AW-1:0] wr_ptr;
  logic [TBL_AW:0] tbl_cnt;
  logic [TBL_AW-1:0] idx;
  logic [NUM_OUT-1:0] pk_state;
  logic [SN_W-1:0] pk_hdr;
  logic [SN_W-1:0] pk_data_sn;
  logic pk_has_data;
  logic [15:0] accept_cnt;
  logic [15:0] reject_cnt;
  shr_state_t state;
  shr_state_t next_state;
  logic [NUM_OUT-1:0] sw_out;

  shr_tbl_if tbl ();

  // strap and learn pin synchronisers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      strap_meta <= 3'h0;
      strap_sync <= 3'h0;
      learn_meta <= 1'b0;
      learn_sync <= 1'b0;
      learn_prev <= 1'b0;
    end
    else if (ce_i)
    begin
      strap_meta <= mode_sel_i;
      strap_sync <= strap_meta;
      learn_meta <= learn_pin_i;
      learn_sync <= learn_meta;
      learn_prev <= learn_sync;
    end
  end

  // straps caught once the synchroniser has filled after each reset release
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      strap_wait <= 2'h0;
      strap_taken <= 1'b0;
      strap_mode <= 3'h0;
    end
    else if (ce_i && !strap_taken)
    begin
      if (strap_wait == STRAP_SETTLE)
      begin
        strap_mode <= strap_sync; // [RULE19]
        strap_taken <= 1'b1;
      end
      else
      begin
        strap_wait <= strap_wait + 2'h1;
      end
    end
  end

  wire logic mode_short;
  wire logic mode_long;
  wire logic mode_net;
  wire logic mode_active;
  wire logic [31:0] hang_period;
  assign mode_short = strap_taken && (strap_mode == STRAP_SHORT || strap_mode == STRAP_SHORT_NET); // [RULE1] [RULE2]
  assign mode_long = strap_taken && (strap_mode == STRAP_LONG || strap_mode == STRAP_LONG_NET); // [RULE16]
  assign mode_net = strap_taken && (strap_mode == STRAP_SHORT_NET || strap_mode == STRAP_LONG_NET); // [RULE2] [RULE16]
  // any other strap setting leaves the outputs low; nothing here ever transmits
  assign mode_active = mode_short | mode_long; // [RULE7]
  // short period: a 15 ms repeat keeps outputs up, all-off lands about 5 ms later
  assign hang_period = mode_long ? HANG_LONG_CYC : HANG_SHORT_CYC; // [RULE10] [RULE12] [RULE14]

  // wishbone decode
  wire logic wb_req;
  wire logic wb_wr;
  wire logic sel_status;
  wire logic sel_ctrl;
  wire logic sel_accept;
  wire logic sel_reject;
  wire logic ctrl_wr;
  wire logic sw_learn_req;
  wire logic sw_clear_req;
  wire logic [31:0] status_word;
  wire logic [31:0] rd_mux;
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_wr = wb_req & wb_we_i & wb_ack_o;
  assign sel_status = wb_adr_i == REG_STATUS;
  assign sel_ctrl = wb_adr_i == REG_CTRL;
  assign sel_accept = wb_adr_i == REG_ACCEPT_CNT;
  assign sel_reject = wb_adr_i == REG_REJECT_CNT;
  assign ctrl_wr = wb_wr & sel_ctrl & wb_sel_i[0];
  assign sw_learn_req = ctrl_wr & wb_dat_i[CTRL_LEARN];
  assign sw_clear_req = ctrl_wr & wb_dat_i[CTRL_CLEAR];
  assign status_word = {16'h0000, tbl_cnt, 1'b0, strap_mode, 1'b0, mode_active, mode_long, mode_net,
                        learning, sw_out};
  assign rd_mux = sel_status ? status_word :
                  sel_ctrl ? {29'h0000_0000, 3'(ctrl_out_off)} :
                  sel_accept ? {16'h0000, accept_cnt} :
                  sel_reject ? {16'h0000, reject_cnt} : 32'h0000_0000;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      if (wb_req && !wb_ack_o)
      begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_out_off <= CTRL_RESET[CTRL_OUT_OFF:CTRL_OUT_OFF];
    end
    else if (ce_i && ctrl_wr)
    begin
      ctrl_out_off <= wb_dat_i[CTRL_OUT_OFF:CTRL_OUT_OFF];
    end
  end

  // packet qualification
  wire logic pkt_take;
  wire logic in_check;
  wire logic check_accept;
  wire logic check_scan;
  wire logic cmp_hit;
  wire logic cmp_last;
  wire logic reject;
  wire logic learn_store;
  wire logic apply;
  assign pkt_busy_o = state != ST_IDLE;
  assign pkt_take = pkt_valid_i & mode_active & (state == ST_IDLE);
  assign in_check = state == ST_CHECK;
  // a serial sender addressing one unit by its data-field serial is matched on ours
  assign check_accept = in_check & (~mode_net | learning | (pk_has_data & pk_data_sn == UNIT_SN)); // [RULE15]
  assign check_scan = in_check & mode_net & ~learning & ~pk_has_data & (tbl_cnt != '0); // [RULE18]
  assign cmp_hit = (state == ST_CMP) & (tbl.rdata == pk_hdr); // [RULE18]
  assign cmp_last = ({1'b0, idx} + 4'h1) == tbl_cnt;
  assign reject = (in_check & ~check_accept & ~check_scan) | ((state == ST_CMP) & ~cmp_hit & cmp_last);
  assign learn_store = in_check & mode_net & learning; // [RULE5]
  assign apply = state == ST_APPLY; // [RULE6]

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (pkt_take)
        begin
          next_state = ST_CHECK;
        end
      end
      ST_CHECK:
      begin
        if (check_accept)
        begin
          next_state = ST_APPLY;
        end
        else if (check_scan)
        begin
          next_state = ST_SCAN;
        end
        else
        begin
          next_state = ST_IDLE;
        end
      end
      ST_SCAN:
      begin
        next_state = ST_CMP;
      end
      ST_CMP:
      begin
        if (cmp_hit)
        begin
          next_state = ST_APPLY;
        end
        else if (cmp_last)
        begin
          next_state = ST_IDLE;
        end
        else
        begin
          next_state = ST_SCAN;
        end
      end
      ST_APPLY:
      begin
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
    end
    else if (ce_i)
    begin
      state <= next_state;
    end
  end

  // packet capture; bits 6..4 of the first byte carry outputs 3..1
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pk_state <= '0;
      pk_hdr <= '0;
      pk_data_sn <= '0;
      pk_has_data <= 1'b0;
    end
    else if (ce_i && pkt_take)
    begin
      pk_state <= pkt_state_i[STATE_LSB +: NUM_OUT]; // [RULE17]
      pk_hdr <= pkt_hdr_sn_i;
      pk_data_sn <= pkt_data_sn_i;
      pk_has_data <= pkt_has_data_sn_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      idx <= '0;
    end
    else if (ce_i)
    begin
      if (in_check)
      begin
        idx <= '0;
      end
      else if (state == ST_CMP)
      begin
        idx <= idx + 3'h1;
      end
    end
  end

  // learn window: opened by a pin pulse or software, closed by a learned packet or timeout
  wire logic learn_start;
  wire logic learn_end;
  assign learn_start = mode_net & ~learning & ((learn_sync & ~learn_prev) | sw_learn_req); // [RULE5]
  assign learn_end = learn_store | (learn_cnt >= LEARN_CYC - 32'h0000_0001);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      learning <= 1'b0;
      learn_cnt <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      if (learn_start)
      begin
        learning <= 1'b1;
        learn_cnt <= 32'h0000_0000;
      end
      else if (learning && learn_end)
      begin
        learning <= 1'b0;
      end
      else if (learning)
      begin
        learn_cnt <= learn_cnt + 32'h0000_0001;
      end
    end
  end

  // the pin is only driven as a status lamp while learning; non-network modes never drive it
  assign learn_pin_o = learning; // [RULE5]
  assign learn_pin_oe_o = learning; // [RULE4]

  // serial table bookkeeping; oldest entry is overwritten once full
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr <= '0;
      tbl_cnt <= '0;
    end
    else if (ce_i)
    begin
      if (sw_clear_req)
      begin
        wr_ptr <= '0;
        tbl_cnt <= '0;
      end
      else if (learn_store)
      begin
        wr_ptr <= wr_ptr + 3'h1;
        if (tbl_cnt != 4'(TBL_DEPTH))
        begin
          tbl_cnt <= tbl_cnt + 4'h1;
        end
      end
    end
  end

  assign tbl.we = learn_store;
  assign tbl.waddr = wr_ptr;
  assign tbl.wdata = pk_hdr;
  assign tbl.raddr = idx;

  shr_sn_table u_table (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .tbl(tbl.mem)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      accept_cnt <= 16'h0000;
      reject_cnt <= 16'h0000;
    end
    else if (ce_i)
    begin
      if (apply)
      begin
        accept_cnt <= accept_cnt + 16'h0001;
      end
      if (reject)
      begin
        reject_cnt <= reject_cnt + 16'h0001;
      end
    end
  end

  wire logic force_off;
  assign force_off = ctrl_out_off[CTRL_OUT_OFF] | ~mode_active;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++)
    begin : g_out
      shr_hang_timer u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .load_i(apply),
        .state_i(pk_state[gi]),
        .clear_i(force_off),
        .period_i(hang_period),
        .out_o(sw_out[gi])
      ); // [RULE20] [RULE8] [RULE3]
    end
  endgenerate

  assign switch_out_1_o = sw_out[0];
  assign switch_out_2_o = sw_out[1];
  assign switch_out_3_o = sw_out[2];
endmodule : shr_switch_receiver
`default_nettype wire

//--- core/shr_tbl_if.sv
`timescale 1ns/10ps
`default_nettype none
interface shr_tbl_if
  import shr_pkg::*;
();
  logic we;
  logic [TBL_AW-1:0] waddr;
  logic [SN_W-1:0] wdata;
  logic [TBL_AW-1:0] raddr;
  logic [SN_W-1:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : shr_tbl_if
`default_nettype wire

//--- sim/shr_switch_receiver_bench.sv
`timescale 1ns/10ps
`default_nettype none
module shr_switch_receiver_bench;
  import shr_pkg::*;
  localparam logic [31:0] HS = 32'h0000_0032;
  localparam logic [31:0] HL = 32'h0000_00c8;
  localparam logic [31:0] SNA = 32'h1234_5678;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] mode = 3'h6;
  logic lrn = 1'b0, bv = 1'b0, tx_en = 1'b0, has_d = 1'b0, drop = 1'b0, cyc = 1'b0, we = 1'b0, ce = 1'b1;
  logic [7:0] bst = 8'h00, adr = 8'h00;
  logic [31:0] bsn = 32'h0000_0000, dsn = 32'h0000_0000, wdat = 32'h0000_0000, rd;
  logic [2:0] tx_in = 3'h0;
  logic [2:0] mt [4] = '{3'h6, 3'h7, 3'h4, 3'h5};
  wire logic mv, busy, ack, l_o, l_oe, o1, o2, o3;
  wire logic [7:0] mst;
  wire logic [31:0] msn, rdat;
  wire logic pin = l_oe ? l_o : lrn;
  integer seed = 32'h0000_cdf1;
  int n_errors = 0, check_count = 0, cyc_n = 0;
  always #4 clk_i = ~clk_i;
  shr_switch_receiver #(.HANG_SHORT_CYC(HS), .HANG_LONG_CYC(HL), .LEARN_CYC(32'h0000_012c)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .mode_sel_i(mode), .learn_pin_i(pin), .learn_pin_o(l_o),
    .learn_pin_oe_o(l_oe), .pkt_valid_i(tx_en ? mv : bv), .pkt_state_i(tx_en ? mst : bst),
    .pkt_hdr_sn_i(tx_en ? msn : bsn), .pkt_has_data_sn_i(has_d), .pkt_data_sn_i(dsn),
    .switch_out_1_o(o1), .switch_out_2_o(o2), .switch_out_3_o(o3), .pkt_busy_o(busy),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack));
  shr_tx_model #(.PERIOD(38), .SN(SNA)) u_tx (.clk_i(clk_i), .rst_i(rst_i), .in_i(tx_in), .drop_i(drop),
    .busy_i(busy), .valid_o(mv), .state_o(mst), .sn_o(msn));
  function automatic logic [31:0] st_exp(input logic [2:0] m);
    return {21'h0, m, 1'b0, 1'b1, ~m[1], m[0], 4'h0};
  endfunction : st_exp
  task automatic fail(input string m);
    n_errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : fail
  task automatic chk_out(input logic [2:0] e);
    check_count++;
    if ({o3, o2, o1} !== e) fail("switch outputs");
  endtask : chk_out
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) fail("value");
  endtask : chk_val
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20) fail("no ack");
    rd = rdat;
    cyc <= 1'b0;
  endtask : wb
  task automatic pkt(input logic [7:0] s, input logic [31:0] h);
    @(posedge clk_i);
    bst <= s;
    bsn <= h;
    bv <= 1'b1;
    @(posedge clk_i);
    bv <= 1'b0;
    bst <= ~s;
    bsn <= ~h;
  endtask : pkt
  task automatic wt;
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      #1;
      n++;
    end while (busy !== 1'b0 && n < 40);
    if (n == 40) fail("engine stuck busy");
  endtask : wt
  task automatic hang(input logic [2:0] e, input logic [31:0] h);
    repeat (h - 1) @(posedge clk_i);
    #1;
    chk_out(e);
    @(posedge clk_i);
    #1;
    chk_out(3'h0);
  endtask : hang
  task automatic do_reset(input logic [2:0] m);
    @(posedge clk_i);
    rst_i <= 1'b1;
    mode <= m;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
    chk_out(3'h0);
  endtask : do_reset
  task automatic run_tx(input logic [2:0] s, input int c);
    @(posedge clk_i);
    tx_en <= 1'b1;
    tx_in <= s;
    repeat (c) @(posedge clk_i);
    #1;
  endtask : run_tx
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      fail("timeout");
      test_done;
    end
  end
  initial
  begin
    logic [7:0] b;
    for (int i = 0; i < 4; i++)
    begin
      do_reset(mt[i]);
      wb(1'b0, REG_STATUS, 32'h0000_0000);
      chk_val(rd & 32'h0000_07ff, st_exp(mt[i]));
    end
    do_reset(3'h6);
    for (int i = 0; i < 16; i++)
    begin
      b = 8'($random(seed));
      if (i < 8) b[6:4] = 3'(i);
      pkt(b, 32'($random(seed)));
      wt;
      chk_out(b[6:4]);
      chk_val({31'h0, l_oe}, 32'h0000_0000);
    end
    pkt(8'h10, SNA);
    wt;
    // ten frozen edges stretch the hang window by ten cycles
    ce <= 1'b0;
    repeat (10) @(posedge clk_i);
    ce <= 1'b1;
    hang(3'h1, HS);
    for (int k = 0; k < 10; k++)
    begin
      run_tx(3'h3, 20);
      chk_out(3'h3);
    end
    run_tx(3'h1, 45);
    chk_out(3'h1);
    run_tx(3'h0, 60);
    chk_out(3'h0);
    tx_en <= 1'b0;
    wb(1'b1, REG_CTRL, 32'h0000_0001);
    pkt(8'h70, SNA);
    wt;
    chk_out(3'h0);
    wb(1'b0, REG_CTRL, 32'h0000_0000);
    chk_val(rd & 32'h0000_0001, 32'h0000_0001);
    wb(1'b1, REG_CTRL, 32'h0000_0000);
    wb(1'b0, 8'h10, 32'h0000_0000);
    chk_val(rd, 32'h0000_0000);
    do_reset(3'h4);
    pkt(8'h50, SNA);
    wt;
    hang(3'h5, HL);
    for (int k = 0; k < 9; k++)
    begin
      drop <= (k % 3) != 0;
      run_tx(3'h7, 40);
      chk_out(3'h7);
    end
    drop <= 1'b0;
    run_tx(3'h7, 40);
    run_tx(3'h0, 120);
    chk_out(3'h7);
    run_tx(3'h0, 130);
    chk_out(3'h0);
    tx_en <= 1'b0;
    do_reset(3'h7);
    wb(1'b1, REG_CTRL, 32'h0000_0004);
    pkt(8'h20, SNA);
    wt;
    chk_out(3'h0);
    @(posedge clk_i);
    lrn <= 1'b1;
    repeat (4) @(posedge clk_i);
    lrn <= 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
    chk_val({31'h0, l_oe & pin}, 32'h0000_0001);
    pkt(8'h20, SNA);
    wt;
    chk_out(3'h2);
    chk_val({31'h0, l_oe}, 32'h0000_0000);
    pkt(8'h40, ~SNA);
    wt;
    chk_out(3'h2);
    has_d <= 1'b1;
    dsn <= UNIT_SN_DEFAULT;
    pkt(8'h10, ~SNA);
    wt;
    chk_out(3'h1);
    dsn <= ~UNIT_SN_DEFAULT;
    pkt(8'h70, SNA);
    wt;
    chk_out(3'h1);
    has_d <= 1'b0;
    pkt(8'h00, SNA);
    wt;
    chk_out(3'h0);
    wb(1'b0, REG_ACCEPT_CNT, 32'h0000_0000);
    chk_val(rd & 32'h0000_ffff, 32'h0000_0003);
    wb(1'b0, REG_REJECT_CNT, 32'h0000_0000);
    chk_val(rd & 32'h0000_ffff, 32'h0000_0003);
    wb(1'b0, REG_STATUS, 32'h0000_0000);
    chk_val(rd & 32'h0000_ffff, 32'h0000_1750);
    wb(1'b1, REG_CTRL, 32'h0000_0004);
    pkt(8'h20, SNA);
    wt;
    chk_out(3'h0);
    test_done;
  end
endmodule : shr_switch_receiver_bench
`default_nettype wire

//--- sim/shr_switch_receiver_checker.sv
`timescale 1ns/10ps
`default_nettype none
module shr_switch_receiver_checker #(
  parameter logic [31:0] HANG_SHORT_CYC = 32'h0000_0032,
  parameter logic [31:0] HANG_LONG_CYC = 32'h0000_00c8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [2:0] mode_sel_i,
  input wire logic learn_pin_o,
  input wire logic learn_pin_oe_o,
  input wire logic pkt_valid_i,
  input wire logic [7:0] pkt_state_i,
  input wire logic switch_out_1_o,
  input wire logic switch_out_2_o,
  input wire logic switch_out_3_o,
  input wire logic pkt_busy_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o
);
  import shr_pkg::*;
  logic [2:0] rc;
  logic [2:0] tp;
  logic [2:0] sp;
  logic off_q;
  logic [31:0] cnt;
  // plain mode with straps settled
  wire logic nn = !mode_sel_i[0] && rc == 3'h7;
  wire logic tk = pkt_valid_i && !pkt_busy_o && nn && !off_q;
  wire logic drop1 = tp[2] && !sp[2];
  wire logic load1 = tp[2] && sp[2];
  wire logic [31:0] hang = mode_sel_i[1] ? HANG_SHORT_CYC : HANG_LONG_CYC;
  wire logic [2:0] outs = {switch_out_3_o, switch_out_2_o, switch_out_1_o};
  wire logic wr_off = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0];
  always_ff @(posedge clk_i)
  begin
    // tracking freezes with the block's clock enable
    if (rst_i || ce_i)
    begin
      rc <= rst_i ? 3'h0 : rc + {2'h0, rc != 3'h7};
      tp <= rst_i ? 3'h0 : {tp[1:0], tk};
      sp <= {sp[1:0], pkt_state_i[4]};
      off_q <= rst_i ? 1'b0 : (wr_off ? wb_dat_i[0] : off_q);
      cnt <= load1 ? 32'h0000_0001 : (switch_out_1_o ? cnt + 32'h0000_0001 : 32'h0000_0000);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);
  AST_LEARN_QUIET: assert property (!mode_sel_i[0] |-> !learn_pin_oe_o)
    else $error("learn pin driven in plain mode");
  AST_PIN_STATUS: assert property (learn_pin_o == learn_pin_oe_o)
    else $error("learn pin level differs from its enable");
  AST_APPLY_STATE: assert property (tk |-> ##3 outs == $past(pkt_state_i[6:4], 3))
    else $error("outputs do not follow packet state");
  AST_HANG_FULL: assert property ($fell(switch_out_1_o) && nn && !off_q && !drop1 |-> cnt == hang)
    else $error("output dropped before hang time");
  AST_HANG_EXPIRE: assert property (switch_out_1_o && nn && !load1 |-> cnt < hang)
    else $error("output held beyond hang time");
  AST_BUSY_SPAN: assert property (tk |=> pkt_busy_o [*2] ##1 !pkt_busy_o)
    else $error("packet engine latency wrong");
  AST_RISE_CAUSE: assert property ($rose(switch_out_1_o) && nn |-> $past(tk, 3) && $past(pkt_state_i[4], 3))
    else $error("output rose without a packet");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not given next cycle");
  COV_ALL_ON: cover property (tk && pkt_state_i[6:4] == 3'h7);
  COV_EXPIRE: cover property ($fell(switch_out_1_o) && cnt == hang);
  COV_LEARN: cover property ($rose(learn_pin_oe_o));
endmodule : shr_switch_receiver_checker
bind shr_switch_receiver shr_switch_receiver_checker #(
  .HANG_SHORT_CYC(HANG_SHORT_CYC), .HANG_LONG_CYC(HANG_LONG_CYC)
) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .mode_sel_i(mode_sel_i), .learn_pin_o(learn_pin_o),
  .learn_pin_oe_o(learn_pin_oe_o), .pkt_valid_i(pkt_valid_i), .pkt_state_i(pkt_state_i),
  .switch_out_1_o(switch_out_1_o), .switch_out_2_o(switch_out_2_o), .switch_out_3_o(switch_out_3_o),
  .pkt_busy_o(pkt_busy_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o)
);
`default_nettype wire

//--- sim/shr_tx_model.sv
`timescale 1ns/10ps
`default_nettype none
module shr_tx_model #(
  parameter int PERIOD = 38,
  parameter logic [31:0] SN = 32'h0000_00a5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] in_i,
  input wire logic drop_i,
  input wire logic busy_i,
  output logic valid_o,
  output logic [7:0] state_o,
  output logic [31:0] sn_o
);
  int t;
  logic [7:0] st;
  wire logic due = in_i != 3'h0 && t >= PERIOD && !busy_i;
  // lines carry a changing pattern between packets
  assign state_o = valid_o ? st : t[7:0];
  assign sn_o = valid_o ? SN : ~SN;
  always_ff @(posedge clk_i)
  begin
    st <= {1'b0, in_i, 4'h0};
    valid_o <= !rst_i && due && !drop_i;
    t <= rst_i ? PERIOD : (due ? 0 : (t < PERIOD ? t + 1 : t));
  end
endmodule : shr_tx_model
`default_nettype wire
